// ==== design/fsr_pkg.sv ====
// Package with encodings, field positions and port structs of the fault status block.
package fsr_pkg;

	// Coprocessor register selectors (opcode1, primary, secondary, opcode2).
	localparam logic [2:0] OPC1_FAULT = 3'h0;
	localparam logic [3:0] CRN_FAULT = 4'h5;
	localparam logic [3:0] CRM_IFS = 4'h0;
	localparam logic [2:0] OPC2_IFS = 3'h1;
	localparam logic [3:0] CRM_ADFS = 4'h1;
	localparam logic [2:0] OPC2_ADFS = 3'h0;
	localparam logic [2:0] OPC2_AIFS = 3'h1;

	// Instruction fault status fields, long layout.
	localparam int IFS_EXT_BIT = 12;
	localparam int IFS_ONE_BIT = 9;
	localparam logic [31:0] IFS_RESET = 32'h0000_0200;
	localparam logic [31:0] IFS_WR_MASK = 32'h0000_103F;

	// Status field prefixes and fixed codes.
	localparam logic [3:0] ST_TRANS = 4'h1;
	localparam logic [3:0] ST_ACCESS = 4'h2;
	localparam logic [3:0] ST_PERM = 4'h3;
	localparam logic [3:0] ST_WALK_EXT = 4'h5;
	localparam logic [3:0] ST_WALK_PAR = 4'h7;
	localparam logic [5:0] ST_SYNC_EXT = 6'h10;
	localparam logic [5:0] ST_SYNC_PAR = 6'h18;
	localparam logic [5:0] ST_DEBUG = 6'h22;

	// Auxiliary data fault status fields.
	localparam int AD_VALID_BIT = 31;
	localparam int AD_L2_BIT = 23;
	localparam logic [6:0] RAM_TAG = 7'h08;
	localparam logic [6:0] RAM_DATA = 7'h09;
	localparam logic [31:0] ADFS_RESET = 32'h0000_0000;

	typedef enum logic [3:0] {
		FSR_TRANS, FSR_ACCESS, FSR_PERM, FSR_SYNC_EXT, FSR_SYNC_PAR,
		FSR_WALK_EXT, FSR_WALK_PAR, FSR_DEBUG, FSR_CACHE_MAINT
	} fsr_kind_e;

	typedef struct packed {
		logic valid;
		fsr_kind_e kind;
		logic [1:0] level;
		logic slave_err;
	} fsr_abort_s;

	typedef struct packed {
		logic valid;
		logic in_l2;
		logic is_data_ram;
		logic [4:0] bank_way;
		logic [17:0] index;
	} fsr_ecc_s;

	typedef struct packed {
		logic rd;
		logic wr;
		logic [2:0] opc1;
		logic [3:0] crn;
		logic [3:0] crm;
		logic [2:0] opc2;
		logic nonsecure;
		logic priv;
		logic [31:0] wdata;
	} fsr_cp_s;

	typedef struct packed {
		logic [31:0] ifs_s;
		logic [31:0] ifs_ns;
		logic [31:0] adfs_s;
		logic [31:0] adfs_ns;
		logic [31:0] rdata;
		logic rvalid;
		logic undef;
	} fsr_state_s;

endpackage : fsr_pkg

// ==== design/fsr_unit.sv ====
// Fault status recording: instruction fault, auxiliary data fault and stub registers.
// Summary of operation
// - Instruction fault register uses long layout when long table format is active.
// - Bit 12 records external abort type: 0 decode error, 1 slave error.
// - External abort type bit is zero for non-external aborts.
// - Translation, access-flag, permission faults encode prefix plus lookup level.
// - Sync external abort fixed code; walk external abort prefix plus level.
// - Sync parity error fixed code; walk parity error prefix plus level.
// - Debug event has own code; reserved encodings are never produced.
// - Lookup level 01 first, 10 second, 11 third; 00 reserved.
// - Cache maintenance aborts do not update the instruction fault register.
// - Instruction fault register decoded at opcode1 0, c5, c0, opcode2 1.
// - Auxiliary data fault register captures L1 and L2 double-bit ECC errors.
// - Bit 31 set when a double-bit error has occurred.
// - Bits 30:24 name the L1 RAM: 0x8 tag, 0x9 data.
// - Bit 23 set when the error came from the level-2 memory.
// - Bits 22:18 record the L1 bank or way.
// - Bits 17:0 record the L1 index.
// - For level-2 errors the identifier, bank/way and index read zero.
// - Auxiliary data register banked by security state; privileged access only.
// - Auxiliary data register decoded at opcode1 0, c5, c1, opcode2 0.
// - Auxiliary instruction register reads zero and ignores writes.
`timescale 1ns/1ps

module fsr_unit (
	// Clock and reset.
	input wire logic mclk,
	input wire logic nrst,
	// Translation format and fault events.
	input wire logic long_format,
	input wire fsr_pkg::fsr_abort_s abort_in,
	input wire fsr_pkg::fsr_ecc_s ecc_in,
	// Coprocessor access.
	input wire fsr_pkg::fsr_cp_s cp_in,
	output logic [31:0] cp_rdata,
	output logic cp_rvalid,
	output logic cp_undef
);
	import fsr_pkg::*;

	fsr_state_s st_q;
	fsr_state_s st_d;
	logic [5:0] status_code;
	logic ext_kind;
	logic level_ok;
	logic abort_take;
	logic [31:0] ifs_word;
	logic [31:0] ecc_word;
	logic hit_ifs;
	logic hit_adfs;
	logic hit_aifs;
	logic [31:0] ifs_cur;
	logic [31:0] adfs_cur;

	// Status field encoder; level 00 is rejected so no reserved code escapes.
	always_comb begin
		status_code = 6'h00;
		ext_kind = 1'b0;
		level_ok = (abort_in.level != 2'h0);
		unique case (abort_in.kind)
			FSR_TRANS: status_code = {ST_TRANS, abort_in.level};
			FSR_ACCESS: status_code = {ST_ACCESS, abort_in.level};
			FSR_PERM: status_code = {ST_PERM, abort_in.level};
			FSR_SYNC_EXT: begin
				status_code = ST_SYNC_EXT;
				ext_kind = 1'b1;
				level_ok = 1'b1;
			end
			FSR_WALK_EXT: begin
				status_code = {ST_WALK_EXT, abort_in.level};
				ext_kind = 1'b1;
			end
			FSR_SYNC_PAR: begin
				status_code = ST_SYNC_PAR;
				level_ok = 1'b1;
			end
			FSR_WALK_PAR: status_code = {ST_WALK_PAR, abort_in.level};
			FSR_DEBUG: begin
				status_code = ST_DEBUG;
				level_ok = 1'b1;
			end
			default: level_ok = 1'b0;
		endcase
	end

	// Only long-format, non-maintenance aborts with a legal code are recorded.
	assign abort_take = abort_in.valid && long_format && level_ok
		&& (abort_in.kind != FSR_CACHE_MAINT);

	always_comb begin
		ifs_word = '0;
		ifs_word[IFS_ONE_BIT] = 1'b1;
		ifs_word[IFS_EXT_BIT] = ext_kind & abort_in.slave_err;
		ifs_word[5:0] = status_code;
	end

	// Level-2 errors leave the L1 location fields at zero.
	always_comb begin
		ecc_word = '0;
		ecc_word[AD_VALID_BIT] = 1'b1;
		ecc_word[AD_L2_BIT] = ecc_in.in_l2;
		if (!ecc_in.in_l2) begin
			ecc_word[30:24] = ecc_in.is_data_ram ? RAM_DATA : RAM_TAG;
			ecc_word[22:18] = ecc_in.bank_way;
			ecc_word[17:0] = ecc_in.index;
		end
	end

	// Register decode.
	assign hit_ifs = cp_in.opc1 == OPC1_FAULT && cp_in.crn == CRN_FAULT
		&& cp_in.crm == CRM_IFS && cp_in.opc2 == OPC2_IFS;
	assign hit_adfs = cp_in.opc1 == OPC1_FAULT && cp_in.crn == CRN_FAULT
		&& cp_in.crm == CRM_ADFS && cp_in.opc2 == OPC2_ADFS;
	assign hit_aifs = cp_in.opc1 == OPC1_FAULT && cp_in.crn == CRN_FAULT
		&& cp_in.crm == CRM_ADFS && cp_in.opc2 == OPC2_AIFS;
	assign ifs_cur = cp_in.nonsecure ? st_q.ifs_ns : st_q.ifs_s;
	assign adfs_cur = cp_in.nonsecure ? st_q.adfs_ns : st_q.adfs_s;

	always_comb begin
		st_d = st_q;
		st_d.rvalid = 1'b0;
		st_d.undef = 1'b0;
		st_d.rdata = '0;
		// Software writes first, so a fault in the same cycle overrides them.
		if (cp_in.wr && cp_in.priv && hit_ifs) begin
			if (cp_in.nonsecure) begin
				st_d.ifs_ns = (cp_in.wdata & IFS_WR_MASK) | IFS_RESET;
			end else begin
				st_d.ifs_s = (cp_in.wdata & IFS_WR_MASK) | IFS_RESET;
			end
		end
		if (cp_in.wr && cp_in.priv && hit_adfs) begin
			if (cp_in.nonsecure) begin
				st_d.adfs_ns = cp_in.wdata;
			end else begin
				st_d.adfs_s = cp_in.wdata;
			end
		end
		if (abort_take) begin
			if (cp_in.nonsecure) begin
				st_d.ifs_ns = ifs_word;
			end else begin
				st_d.ifs_s = ifs_word;
			end
		end
		if (ecc_in.valid) begin
			if (cp_in.nonsecure) begin
				st_d.adfs_ns = ecc_word;
			end else begin
				st_d.adfs_s = ecc_word;
			end
		end
		if (cp_in.rd || cp_in.wr) begin
			if (!cp_in.priv || !(hit_ifs || hit_adfs || hit_aifs)) begin
				st_d.undef = 1'b1;
			end else if (cp_in.rd) begin
				st_d.rvalid = 1'b1;
				if (hit_ifs) begin
					st_d.rdata = ifs_cur;
				end else if (hit_adfs) begin
					st_d.rdata = adfs_cur;
				end else begin
					st_d.rdata = '0;
				end
			end
		end
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			st_q <= '{ifs_s: IFS_RESET, ifs_ns: IFS_RESET, adfs_s: ADFS_RESET,
				adfs_ns: ADFS_RESET, rdata: 32'h0000_0000, rvalid: 1'b0, undef: 1'b0};
		end else begin
			st_q <= st_d;
		end
	end

	assign cp_rdata = st_q.rdata;
	assign cp_rvalid = st_q.rvalid;
	assign cp_undef = st_q.undef;

	// Checks.
	chk_ifs_bit_one: assert property (@(posedge mclk) disable iff (!nrst)
		st_q.ifs_s[IFS_ONE_BIT] && st_q.ifs_ns[IFS_ONE_BIT])
		else $error("instruction fault bit 9 not one");
	chk_ext_nonext: assert property (@(posedge mclk) disable iff (!nrst)
		abort_take && !ext_kind && !cp_in.nonsecure |=> !st_q.ifs_s[IFS_EXT_BIT])
		else $error("external type set on non-external abort");
	chk_ext_record: assert property (@(posedge mclk) disable iff (!nrst)
		abort_take && ext_kind && !cp_in.nonsecure
		|=> st_q.ifs_s[IFS_EXT_BIT] == $past(abort_in.slave_err))
		else $error("external abort type not recorded");
	chk_short_ignored: assert property (@(posedge mclk) disable iff (!nrst)
		abort_in.valid && !long_format && !cp_in.wr && !cp_in.nonsecure
		|=> $stable(st_q.ifs_s))
		else $error("short format abort changed register");
	chk_maint_ignored: assert property (@(posedge mclk) disable iff (!nrst)
		abort_in.valid && abort_in.kind == FSR_CACHE_MAINT && !cp_in.wr
		|=> $stable(st_q.ifs_s) && $stable(st_q.ifs_ns))
		else $error("maintenance abort changed instruction register");
	chk_debug_code: assert property (@(posedge mclk) disable iff (!nrst)
		abort_take && abort_in.kind == FSR_DEBUG && !cp_in.nonsecure
		|=> st_q.ifs_s[5:0] == 6'h22)
		else $error("debug code wrong");
	chk_level_code: assert property (@(posedge mclk) disable iff (!nrst)
		abort_take && abort_in.kind == FSR_TRANS && !cp_in.nonsecure
		|=> st_q.ifs_s[5:0] == {4'h1, $past(abort_in.level)} && st_q.ifs_s[1:0] != 2'h0)
		else $error("translation code wrong");
	chk_ecc_valid: assert property (@(posedge mclk) disable iff (!nrst)
		ecc_in.valid && !cp_in.nonsecure |=> st_q.adfs_s[31])
		else $error("ecc valid not set");
	chk_ecc_l2_zero: assert property (@(posedge mclk) disable iff (!nrst)
		ecc_in.valid && ecc_in.in_l2 && !cp_in.nonsecure
		|=> st_q.adfs_s[23] && st_q.adfs_s[30:24] == 7'h00 && st_q.adfs_s[22:0] == 23'h0)
		else $error("level-2 error fields not zero");
	chk_ecc_l1_ram: assert property (@(posedge mclk) disable iff (!nrst)
		ecc_in.valid && !ecc_in.in_l2 && !cp_in.nonsecure
		|=> st_q.adfs_s[30:24] == ($past(ecc_in.is_data_ram) ? 7'h09 : 7'h08)
		&& st_q.adfs_s[17:0] == $past(ecc_in.index)
		&& st_q.adfs_s[22:18] == $past(ecc_in.bank_way))
		else $error("level-1 ram fields wrong");
	chk_aifs_zero: assert property (@(posedge mclk) disable iff (!nrst)
		cp_in.rd && cp_in.priv && hit_aifs |=> cp_rvalid && cp_rdata == 32'h0)
		else $error("auxiliary instruction register not zero");
	chk_unpriv_undef: assert property (@(posedge mclk) disable iff (!nrst)
		cp_in.rd && !cp_in.priv |=> cp_undef && !cp_rvalid)
		else $error("unprivileged access not refused");
	chk_ifs_read: assert property (@(posedge mclk) disable iff (!nrst)
		cp_in.rd && cp_in.priv && hit_ifs |=> cp_rvalid && cp_rdata[9])
		else $error("instruction register read wrong");
	chk_adfs_read: assert property (@(posedge mclk) disable iff (!nrst)
		cp_in.rd && cp_in.priv && hit_adfs && !cp_in.nonsecure
		|=> cp_rvalid && cp_rdata == $past(st_q.adfs_s))
		else $error("auxiliary data register read wrong");

	// Further checks on encodings, banking and refused accesses.
	chk_ns_abort: assert property (@(posedge mclk) disable iff (!nrst)
		abort_take && abort_in.kind == FSR_SYNC_EXT && cp_in.nonsecure
		|=> st_q.ifs_ns[5:0] == 6'h10)
		else $error("nonsecure external abort code wrong");
	chk_walk_ext_code: assert property (@(posedge mclk) disable iff (!nrst)
		abort_take && abort_in.kind == FSR_WALK_EXT && !cp_in.nonsecure
		|=> st_q.ifs_s[5:0] == {4'h5, $past(abort_in.level)})
		else $error("walk external abort code wrong");
	chk_sync_par_code: assert property (@(posedge mclk) disable iff (!nrst)
		abort_take && abort_in.kind == FSR_SYNC_PAR && !cp_in.nonsecure
		|=> st_q.ifs_s[5:0] == 6'h18 && !st_q.ifs_s[12])
		else $error("parity error code wrong");
	chk_walk_par_code: assert property (@(posedge mclk) disable iff (!nrst)
		abort_take && abort_in.kind == FSR_WALK_PAR && !cp_in.nonsecure
		|=> st_q.ifs_s[5:0] == {4'h7, $past(abort_in.level)})
		else $error("walk parity error code wrong");
	chk_access_code: assert property (@(posedge mclk) disable iff (!nrst)
		abort_take && abort_in.kind == FSR_ACCESS && !cp_in.nonsecure
		|=> st_q.ifs_s[5:0] == {4'h2, $past(abort_in.level)})
		else $error("access flag code wrong");
	chk_perm_code: assert property (@(posedge mclk) disable iff (!nrst)
		abort_take && abort_in.kind == FSR_PERM && !cp_in.nonsecure
		|=> st_q.ifs_s[5:0] == {4'h3, $past(abort_in.level)})
		else $error("permission code wrong");
	chk_level_zero: assert property (@(posedge mclk) disable iff (!nrst)
		abort_in.valid && abort_in.level == 2'h0 && !cp_in.wr
		&& abort_in.kind inside {FSR_TRANS, FSR_ACCESS, FSR_PERM, FSR_WALK_EXT, FSR_WALK_PAR}
		|=> $stable(st_q.ifs_s) && $stable(st_q.ifs_ns))
		else $error("reserved level recorded");
	chk_reserved_bits: assert property (@(posedge mclk) disable iff (!nrst)
		st_q.ifs_s[31:13] == 19'h0 && st_q.ifs_s[11:10] == 2'h0 && st_q.ifs_s[8:6] == 3'h0
		&& st_q.ifs_ns[31:13] == 19'h0 && st_q.ifs_ns[11:10] == 2'h0 && st_q.ifs_ns[8:6] == 3'h0)
		else $error("reserved instruction fault bits set");
	chk_adfs_ns_ecc: assert property (@(posedge mclk) disable iff (!nrst)
		ecc_in.valid && cp_in.nonsecure |=> st_q.adfs_ns[31])
		else $error("nonsecure ecc valid not set");
	chk_ns_ecc_l2: assert property (@(posedge mclk) disable iff (!nrst)
		ecc_in.valid && ecc_in.in_l2 && cp_in.nonsecure
		|=> st_q.adfs_ns[30:0] == 31'h0080_0000)
		else $error("nonsecure level-2 fields not zero");
	chk_ecc_l1_clear: assert property (@(posedge mclk) disable iff (!nrst)
		ecc_in.valid && !ecc_in.in_l2 && !cp_in.nonsecure |=> !st_q.adfs_s[23])
		else $error("level-2 bit set on level-1 error");
	chk_adfs_write: assert property (@(posedge mclk) disable iff (!nrst)
		cp_in.wr && cp_in.priv && hit_adfs && !ecc_in.valid && !cp_in.nonsecure
		|=> st_q.adfs_s == $past(cp_in.wdata))
		else $error("auxiliary data write lost");
	chk_ifs_write: assert property (@(posedge mclk) disable iff (!nrst)
		cp_in.wr && cp_in.priv && hit_ifs && !abort_take && !cp_in.nonsecure
		|=> st_q.ifs_s == (($past(cp_in.wdata) & 32'h0000_103F) | 32'h0000_0200))
		else $error("instruction fault write mask wrong");
	chk_aifs_ignored: assert property (@(posedge mclk) disable iff (!nrst)
		cp_in.wr && hit_aifs && !abort_in.valid && !ecc_in.valid
		|=> $stable(st_q.ifs_s) && $stable(st_q.ifs_ns) && $stable(st_q.adfs_s)
		&& $stable(st_q.adfs_ns))
		else $error("auxiliary instruction write took effect");
	chk_unpriv_nowrite: assert property (@(posedge mclk) disable iff (!nrst)
		cp_in.wr && !cp_in.priv && !abort_in.valid && !ecc_in.valid
		|=> cp_undef && $stable(st_q.ifs_s) && $stable(st_q.ifs_ns)
		&& $stable(st_q.adfs_s) && $stable(st_q.adfs_ns))
		else $error("unprivileged write took effect");
	chk_unmapped_undef: assert property (@(posedge mclk) disable iff (!nrst)
		(cp_in.rd || cp_in.wr) && !(hit_ifs || hit_adfs || hit_aifs)
		|=> cp_undef && !cp_rvalid)
		else $error("unmapped selector not refused");
	chk_no_answer: assert property (@(posedge mclk) disable iff (!nrst)
		!cp_in.rd && !cp_in.wr |=> !cp_rvalid && !cp_undef && cp_rdata == 32'h0)
		else $error("answer without request");
	chk_ns_ifs_read: assert property (@(posedge mclk) disable iff (!nrst)
		cp_in.rd && cp_in.priv && hit_ifs && cp_in.nonsecure
		|=> cp_rvalid && cp_rdata == $past(st_q.ifs_ns))
		else $error("nonsecure instruction register read wrong");
	chk_event_wins: assert property (@(posedge mclk) disable iff (!nrst)
		ecc_in.valid && cp_in.wr && cp_in.priv && hit_adfs && !cp_in.nonsecure
		|=> st_q.adfs_s[31] && st_q.adfs_s[23] == $past(ecc_in.in_l2))
		else $error("software write beat ecc event");

	cov_walk_ext: cover property (@(posedge mclk) disable iff (!nrst)
		abort_take && abort_in.kind == FSR_WALK_EXT);
	cov_ecc_l2: cover property (@(posedge mclk) disable iff (!nrst)
		ecc_in.valid && ecc_in.in_l2);
	cov_ecc_read: cover property (@(posedge mclk) disable iff (!nrst)
		ecc_in.valid ##1 cp_in.rd && hit_adfs);
	cov_aifs: cover property (@(posedge mclk) disable iff (!nrst)
		cp_in.wr && hit_aifs && cp_in.priv);
	cov_unpriv_write: cover property (@(posedge mclk) disable iff (!nrst)
		cp_in.wr && !cp_in.priv && hit_adfs);

endmodule : fsr_unit

// ==== test/fsr_testbench.sv ====
// Self-checking testbench for the fault status recording unit.
`timescale 1ns/1ps

module testbench;
	import fsr_pkg::*;

	logic mclk, nrst, long_format;
	fsr_abort_s abort_in;
	fsr_ecc_s ecc_in;
	fsr_cp_s cp_in;
	logic [31:0] cp_rdata, got_data;
	logic cp_rvalid, cp_undef, got_valid, got_undef;
	int num_errors = 0;
	int num_checks = 0;
	int cycles = 0;

	fsr_unit uut (.mclk(mclk), .nrst(nrst), .long_format(long_format), .abort_in(abort_in),
		.ecc_in(ecc_in), .cp_in(cp_in), .cp_rdata(cp_rdata), .cp_rvalid(cp_rvalid),
		.cp_undef(cp_undef));

	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end

	// The whole run takes well under a thousand cycles.
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 3000) begin
			num_errors++;
			$display("BAD %0t timeout", $time);
			give_verdict();
		end
	end

	task give_verdict;
		$display("checks %0d mismatches %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : give_verdict

	task check(input logic [31:0] got, input logic [31:0] exp, input string what);
		num_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("BAD %0t %s got %h expected %h", $time, what, got, exp);
		end
	endtask : check

	// One request pulse, answer sampled half a cycle after the taking edge.
	task access(input logic rd, input logic wr, input logic [2:0] o1, input logic [3:0] crm,
		input logic [2:0] o2, input logic ns, input logic pv, input logic [31:0] wd);
		@(negedge mclk);
		cp_in = '{rd: rd, wr: wr, opc1: o1, crn: CRN_FAULT, crm: crm, opc2: o2,
			nonsecure: ns, priv: pv, wdata: wd};
		@(negedge mclk);
		cp_in.rd = 1'b0;
		cp_in.wr = 1'b0;
		got_data = cp_rdata;
		got_valid = cp_rvalid;
		got_undef = cp_undef;
	endtask : access

	task rd_chk(input logic [3:0] crm, input logic [2:0] o2, input logic ns,
		input logic [31:0] exp, input string what);
		access(1'b1, 1'b0, OPC1_FAULT, crm, o2, ns, 1'b1, 32'h0);
		check({31'h0, got_valid}, 32'h1, "read answered");
		check(got_data, exp, what);
		@(negedge mclk);
		check({30'h0, cp_rvalid, cp_undef}, 32'h0, "answer lasts one cycle");
	endtask : rd_chk

	task fire_abort(input fsr_kind_e kind, input logic [1:0] lvl, input logic se);
		@(negedge mclk);
		cp_in.nonsecure = 1'b0;
		abort_in = '{valid: 1'b1, kind: kind, level: lvl, slave_err: se};
		@(negedge mclk);
		abort_in.valid = 1'b0;
	endtask : fire_abort

	task test_reset;
		rd_chk(CRM_IFS, OPC2_IFS, 1'b0, 32'h0000_0200, "ifs reset");
		rd_chk(CRM_ADFS, OPC2_ADFS, 1'b1, 32'h0000_0000, "adfs reset");
		$display("test reset done");
	endtask : test_reset

	task test_aborts;
		fsr_kind_e k;
		logic [5:0] st;
		logic external_abort_type;
		long_format = 1'b1;
		for (int i = 0; i < 8; i++) begin
			k = fsr_kind_e'(i);
			for (int l = 1; l < 4; l++) begin
				for (int s = 0; s < 2; s++) begin
					case (k)
						FSR_TRANS: st = {ST_TRANS, 2'(l)};
						FSR_ACCESS: st = {ST_ACCESS, 2'(l)};
						FSR_PERM: st = {ST_PERM, 2'(l)};
						FSR_WALK_EXT: st = {ST_WALK_EXT, 2'(l)};
						FSR_WALK_PAR: st = {ST_WALK_PAR, 2'(l)};
						FSR_SYNC_EXT: st = ST_SYNC_EXT;
						FSR_SYNC_PAR: st = ST_SYNC_PAR;
						default: st = ST_DEBUG;
					endcase
					external_abort_type = (s == 1) && (k == FSR_SYNC_EXT || k == FSR_WALK_EXT);
					fire_abort(k, 2'(l), 1'(s));
					rd_chk(CRM_IFS, OPC2_IFS, 1'b0, {19'h0, external_abort_type, 6'h08, st}, "ifs code");
				end
			end
		end
		$display("test aborts done");
	endtask : test_aborts

	task test_ignored;
		fire_abort(FSR_DEBUG, 2'h1, 1'b0);
		fire_abort(FSR_TRANS, 2'h0, 1'b0);
		rd_chk(CRM_IFS, OPC2_IFS, 1'b0, 32'h0000_0222, "level zero kept out");
		fire_abort(FSR_CACHE_MAINT, 2'h1, 1'b1);
		rd_chk(CRM_IFS, OPC2_IFS, 1'b0, 32'h0000_0222, "cache maint kept out");
		long_format = 1'b0;
		fire_abort(FSR_PERM, 2'h2, 1'b0);
		rd_chk(CRM_IFS, OPC2_IFS, 1'b0, 32'h0000_0222, "short format kept out");
		long_format = 1'b1;
		$display("test ignored done");
	endtask : test_ignored

	task test_ecc;
		logic [31:0] exp [3] = '{32'h887F_FFFF, 32'h8928_1234, 32'h8080_0000};
		fsr_ecc_s ev [3] = '{'{1'b1, 1'b0, 1'b0, 5'h1F, 18'h3FFFF},
			'{1'b1, 1'b0, 1'b1, 5'h0A, 18'h01234}, '{1'b1, 1'b1, 1'b1, 5'h15, 18'h2AAAA}};
		for (int i = 0; i < 3; i++) begin
			@(negedge mclk);
			cp_in.nonsecure = 1'b0;
			ecc_in = ev[i];
			@(negedge mclk);
			ecc_in.valid = 1'b0;
			rd_chk(CRM_ADFS, OPC2_ADFS, 1'b0, exp[i], "adfs syndrome");
		end
		rd_chk(CRM_ADFS, OPC2_ADFS, 1'b1, 32'h0000_0000, "other bank untouched");
		$display("test ecc done");
	endtask : test_ecc

	task test_access;
		access(1'b0, 1'b1, OPC1_FAULT, CRM_ADFS, OPC2_ADFS, 1'b1, 1'b1, 32'h0BAD_F00D);
		rd_chk(CRM_ADFS, OPC2_ADFS, 1'b1, 32'h0BAD_F00D, "nonsecure bank");
		access(1'b0, 1'b1, OPC1_FAULT, CRM_ADFS, OPC2_ADFS, 1'b1, 1'b0, 32'hFFFF_FFFF);
		rd_chk(CRM_ADFS, OPC2_ADFS, 1'b1, 32'h0BAD_F00D, "unprivileged write kept out");
		rd_chk(CRM_ADFS, OPC2_ADFS, 1'b0, 32'h8080_0000, "secure bank kept");
		access(1'b1, 1'b0, OPC1_FAULT, CRM_ADFS, OPC2_ADFS, 1'b0, 1'b0, 32'h0);
		check({30'h0, got_valid, got_undef}, 32'h1, "unprivileged refused");
		access(1'b1, 1'b0, 3'h1, CRM_IFS, OPC2_IFS, 1'b0, 1'b1, 32'h0);
		check({30'h0, got_valid, got_undef}, 32'h1, "wrong opcode1 refused");
		access(1'b0, 1'b1, OPC1_FAULT, CRM_IFS, OPC2_IFS, 1'b0, 1'b1, 32'hFFFF_FFFF);
		rd_chk(CRM_IFS, OPC2_IFS, 1'b0, 32'h0000_123F, "ifs write mask");
		access(1'b0, 1'b1, OPC1_FAULT, CRM_ADFS, OPC2_AIFS, 1'b0, 1'b1, 32'hFFFF_FFFF);
		rd_chk(CRM_ADFS, OPC2_AIFS, 1'b0, 32'h0000_0000, "aifs reads zero");
		$display("test access done");
	endtask : test_access

	initial begin
		nrst = 1'b0;
		long_format = 1'b1;
		abort_in = '0;
		ecc_in = '0;
		cp_in = '0;
		repeat (4) @(negedge mclk);
		nrst = 1'b1;
		test_reset();
		test_aborts();
		test_ignored();
		test_ecc();
		test_access();
		give_verdict();
	end

endmodule : testbench
